// ### common/pae_defines.svh
// constants of the phase active energy accumulator: widths, offsets, bits, timing
// assumes a single 100 MHz system clock and a 32-bit Avalon-MM register port
`ifndef PAE_DEFINES_SVH
`define PAE_DEFINES_SVH

`define PAE_CLK_MHZ 100
`define PAE_SAMPLE_TIME_NS 400
`define PAE_SAMPLE_CYCLES ((`PAE_SAMPLE_TIME_NS * `PAE_CLK_MHZ) / 1000)
`define PAE_TICK_CNT_W 8

`define PAE_SAMPLE_W 24
`define PAE_CURR_W 25
`define PAE_POWER_W 25
`define PAE_ADDEND_W 26
`define PAE_ACC_W 41
`define PAE_VIS_W 16
`define PAE_GAIN_W 12
`define PAE_DIV_W 8
`define PAE_LPF_SHIFT 4
`define PAE_PROD_SHIFT 23
`define PAE_GAIN_SHIFT 12
`define PAE_GAIN_ONE 14'sh1000
`define PAE_CREEP_THRESHOLD 25'h000002A
`define PAE_VIS_HALF_BIT 14

`define PAE_ADDR_W 8
`define PAE_OFS_ENERGY_A 8'h00
`define PAE_OFS_ENERGY_B 8'h04
`define PAE_OFS_ENERGY_C 8'h08
`define PAE_OFS_DIVIDER 8'h0C
`define PAE_OFS_COMP_MODE 8'h10
`define PAE_OFS_LINE_MODE 8'h14
`define PAE_OFS_INT_STATUS 8'h18
`define PAE_OFS_INT_CLEAR 8'h1C
`define PAE_OFS_INT_MASK 8'h20
`define PAE_OFS_PGAIN_A 8'h24
`define PAE_OFS_PGAIN_B 8'h28
`define PAE_OFS_PGAIN_C 8'h2C
`define PAE_OFS_CURRENT_GAIN_A 8'h30
`define PAE_OFS_CURRENT_GAIN_B 8'h34
`define PAE_OFS_CURRENT_GAIN_C 8'h38

`define PAE_COMB_LSB 0
`define PAE_PHSEL_LSB 2
`define PAE_CREEP_BIT 7
`define PAE_CLR_ON_READ_BIT 6
`define PAE_INT_HALF_BIT 0
`define PAE_INT_SIGN_BIT 1
`define PAE_INT_W 2

`define PAE_DIV_RST 8'h00
`define PAE_COMP_RST 8'h1C
`define PAE_LINE_RST 8'h00
`define PAE_MASK_RST 2'h0
`define PAE_GAIN_RST 12'h000

`endif

// ### common/pae_pkg.sv
// types shared by the phase active energy accumulator modules
// assumes pae_defines.svh is on the include path
`include "pae_defines.svh"

package pae_pkg;

    typedef enum logic [1:0] {
        PAE_COMB_OWN,
        PAE_COMB_DIFF_AC,
        PAE_COMB_DIFF_A,
        PAE_COMB_RSVD
    } pae_comb_t;

    typedef logic signed [`PAE_SAMPLE_W-1:0] pae_sample_t;
    typedef logic signed [`PAE_CURR_W-1:0] pae_curr_t;
    typedef logic signed [`PAE_POWER_W-1:0] pae_power_t;
    typedef logic signed [`PAE_ADDEND_W-1:0] pae_addend_t;

    typedef struct packed {
        logic signed [`PAE_GAIN_W-1:0] power_gain;
        logic [`PAE_DIV_W-1:0] divider;
        logic creep_en;
    } pae_phase_cfg_t;

    typedef struct packed {
        logic [`PAE_VIS_W-1:0] energy;
        logic half_full_evt;
        pae_addend_t addend;
    } pae_acc_out_t;

endpackage

// ### core/pae_phase_acc.sv
// one phase: power gain, creep cut, divider and wide wrapping energy register
// assumes avg_power steady between ticks and clear as a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
`include "pae_defines.svh"

module pae_phase_acc (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic tick,
    input wire pae_pkg::pae_power_t avg_power,
    input wire pae_pkg::pae_phase_cfg_t cfg,
    input wire logic clear,
    output pae_pkg::pae_acc_out_t acc_out
);
    localparam int GPROD_W = `PAE_POWER_W + 14;

    logic signed [13:0] gain_factor;
    logic signed [GPROD_W-1:0] gain_prod;
    logic signed [GPROD_W-1:0] gain_sh;
    pae_pkg::pae_addend_t gained;
    logic [`PAE_POWER_W-1:0] avg_mag;
    logic below_creep;
    logic [`PAE_ADDEND_W-1:0] gained_mag;
    logic [`PAE_ADDEND_W-1:0] quotient;
    pae_pkg::pae_addend_t divided;
    pae_pkg::pae_addend_t addend;
    logic signed [`PAE_ACC_W-1:0] acc;
    logic signed [`PAE_ACC_W-1:0] acc_base;
    logic signed [`PAE_ACC_W-1:0] next_acc;

    assign gain_factor = `PAE_GAIN_ONE + {{2{cfg.power_gain[`PAE_GAIN_W-1]}}, cfg.power_gain};
    assign gain_prod = avg_power * gain_factor;
    assign gain_sh = gain_prod >>> `PAE_GAIN_SHIFT;
    assign gained = gain_sh[`PAE_ADDEND_W-1:0];

    // creep compares the unscaled average, both polarities, active path only
    assign avg_mag = avg_power[`PAE_POWER_W-1] ? `PAE_POWER_W'(-avg_power) : avg_power;
    assign below_creep = cfg.creep_en && (avg_mag < `PAE_CREEP_THRESHOLD);

    // divide the magnitude so rounding is symmetric about zero
    assign gained_mag = gained[`PAE_ADDEND_W-1] ? `PAE_ADDEND_W'(-gained) : gained;
    assign quotient = (cfg.divider > `PAE_DIV_W'(1)) ?
        gained_mag / {{(`PAE_ADDEND_W-`PAE_DIV_W){1'b0}}, cfg.divider} : gained_mag;
    assign divided = gained[`PAE_ADDEND_W-1] ? -$signed(quotient) : $signed(quotient);
    assign addend = below_creep ? '0 : divided;

    assign acc_base = clear ? '0 : acc;
    // plain two's complement add: wraps both ways without saturation
    assign next_acc = acc_base + (tick ? {{(`PAE_ACC_W-`PAE_ADDEND_W){addend[`PAE_ADDEND_W-1]}}, addend} : '0);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            acc <= '0;
            acc_out <= '0;
        end else begin
            acc <= next_acc;
            acc_out.energy <= next_acc[`PAE_ACC_W-1 -: `PAE_VIS_W];
            acc_out.half_full_evt <= tick && (next_acc[`PAE_ACC_W-`PAE_VIS_W+`PAE_VIS_HALF_BIT]
                != acc[`PAE_ACC_W-`PAE_VIS_W+`PAE_VIS_HALF_BIT]);
            if (tick) begin
                acc_out.addend <= addend;
            end
        end
    end
endmodule

`default_nettype wire

// ### core/pae_power_path.sv
// one phase: voltage times current, then first-order power lowpass
// assumes samples on the system clock; tick marks each accumulation period
`timescale 1ns/1ps
`default_nettype none
`include "pae_defines.svh"

module pae_power_path (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic tick,
    input wire pae_pkg::pae_sample_t voltage,
    input wire pae_pkg::pae_curr_t current,
    output pae_pkg::pae_power_t avg_power
);
    localparam int PROD_W = `PAE_SAMPLE_W + `PAE_CURR_W;
    localparam int LPF_W = `PAE_POWER_W + `PAE_LPF_SHIFT;

    logic signed [PROD_W-1:0] product;
    logic signed [PROD_W-1:0] product_sh;
    logic signed [LPF_W-1:0] lpf_state;
    logic signed [LPF_W-1:0] lpf_in;
    logic signed [LPF_W-1:0] next_lpf;

    assign product = voltage * current;
    assign product_sh = product >>> `PAE_PROD_SHIFT;
    assign lpf_in = {{`PAE_LPF_SHIFT{product_sh[`PAE_POWER_W-1]}}, product_sh[`PAE_POWER_W-1:0]};
    // leaky integrator: state holds the average scaled by 2^shift
    assign next_lpf = lpf_state + lpf_in - (lpf_state >>> `PAE_LPF_SHIFT);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lpf_state <= '0;
            avg_power <= '0;
        end else if (tick) begin
            lpf_state <= next_lpf;
            avg_power <= next_lpf[LPF_W-1:`PAE_LPF_SHIFT];
        end
    end
endmodule

`default_nettype wire

// ### core/pae_top.sv
// phase active energy accumulator top: current gain, input combination,
// three power paths and accumulators, Avalon-MM registers and interrupt
// assumes samples synchronous to clk_sys and a single Avalon-MM master
//
// Operation
// - With creep cut enabled, a phase whose average power is under the threshold adds nothing.
// - The creep cut acts on active energy only and never on reactive or apparent energy.
// - Each phase keeps a 41-bit energy register whose top 16 bits software reads.
// - Accumulation is signed so negative power lowers the energy register.
// - Gained power is divided by the unsigned divider before accumulation, with 0 or 1 meaning no division.
// - The energy register wraps from top positive to full negative and back without saturating.
// - A change of visible bit 14 on any phase raises the half-full event, which drives the low-active interrupt when enabled.
// - With clear-on-read set, reading a phase energy register zeroes it after the read.
// - One new averaged power sample is added every 40 system-clock periods.
// - The combination field picks own products, A(IA-IB)/0/C(IC-IB), or A(IA-IB)/0/C*IC, with 11 reserved.
// - Accumulated energy reflects both the phase current gain and its power gain.
// - Current gain acts on the current waveform itself so every result derived from it follows.
// - Power gain is signed 12-bit and scales by one plus gain over 4096.
// - The phase selection field picks the phases in sign monitoring and in the power total.
//
// The Avalon-MM register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pae_defines.svh"

module pae_top (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [`PAE_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire pae_pkg::pae_sample_t voltage_a,
    input wire pae_pkg::pae_sample_t voltage_b,
    input wire pae_pkg::pae_sample_t voltage_c,
    input wire pae_pkg::pae_sample_t current_a,
    input wire pae_pkg::pae_sample_t current_b,
    input wire pae_pkg::pae_sample_t current_c,
    output pae_pkg::pae_sample_t gained_current_a,
    output pae_pkg::pae_sample_t gained_current_b,
    output pae_pkg::pae_sample_t gained_current_c,
    output logic [2:0] phase_sign_negative,
    output logic signed [`PAE_ADDEND_W+1:0] total_active_power,
    output logic irq_n
);
    // sample period timer
    logic [`PAE_TICK_CNT_W-1:0] tick_cnt;
    logic tick;

    assign tick = (tick_cnt == `PAE_TICK_CNT_W'(`PAE_SAMPLE_CYCLES - 1));

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tick_cnt <= '0;
        end else if (tick) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick_cnt + `PAE_TICK_CNT_W'(1);
        end
    end

    // registers
    logic [`PAE_DIV_W-1:0] energy_divider;
    logic [7:0] compensation_mode_reg;
    logic [7:0] line_cycle_mode_reg;
    logic [`PAE_INT_W-1:0] int_status;
    logic [`PAE_INT_W-1:0] energy_half_full_mask;
    logic [2:0][`PAE_GAIN_W-1:0] power_gain;
    logic [2:0][`PAE_GAIN_W-1:0] current_gain;

    pae_pkg::pae_comb_t input_combination_select;
    logic [2:0] phase_selection;
    logic creep_threshold_enable;
    logic clear_on_read_enable;

    assign input_combination_select = pae_pkg::pae_comb_t'(compensation_mode_reg[`PAE_COMB_LSB +: 2]);
    assign phase_selection = compensation_mode_reg[`PAE_PHSEL_LSB +: 3];
    assign creep_threshold_enable = compensation_mode_reg[`PAE_CREEP_BIT];
    assign clear_on_read_enable = line_cycle_mode_reg[`PAE_CLR_ON_READ_BIT];

    // current gain on the waveform, shared by every consumer of the current
    pae_pkg::pae_sample_t raw_current [3];
    pae_pkg::pae_sample_t gained_current [3];

    assign raw_current[0] = current_a;
    assign raw_current[1] = current_b;
    assign raw_current[2] = current_c;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_current_gain
            logic signed [13:0] factor;
            logic signed [`PAE_SAMPLE_W+13:0] prod;
            logic signed [`PAE_SAMPLE_W+13:0] prod_sh;
            assign factor = `PAE_GAIN_ONE + {{2{current_gain[gi][`PAE_GAIN_W-1]}}, current_gain[gi]};
            assign prod = raw_current[gi] * factor;
            assign prod_sh = prod >>> `PAE_GAIN_SHIFT;
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    gained_current[gi] <= '0;
                end else begin
                    gained_current[gi] <= prod_sh[`PAE_SAMPLE_W-1:0];
                end
            end
        end
    endgenerate

    assign gained_current_a = gained_current[0];
    assign gained_current_b = gained_current[1];
    assign gained_current_c = gained_current[2];

    // input combination; reserved code accumulates nothing
    pae_pkg::pae_curr_t ia;
    pae_pkg::pae_curr_t ib;
    pae_pkg::pae_curr_t ic;
    pae_pkg::pae_curr_t ia_minus_ib;
    pae_pkg::pae_curr_t ic_minus_ib;
    pae_pkg::pae_curr_t sel_curr [3];
    pae_pkg::pae_sample_t sel_volt [3];
    logic comb_own;
    logic comb_diff;

    assign ia = {gained_current[0][`PAE_SAMPLE_W-1], gained_current[0]};
    assign ib = {gained_current[1][`PAE_SAMPLE_W-1], gained_current[1]};
    assign ic = {gained_current[2][`PAE_SAMPLE_W-1], gained_current[2]};
    assign ia_minus_ib = ia - ib;
    assign ic_minus_ib = ic - ib;
    assign comb_own = (input_combination_select == pae_pkg::PAE_COMB_OWN);
    assign comb_diff = (input_combination_select == pae_pkg::PAE_COMB_DIFF_AC) ||
                       (input_combination_select == pae_pkg::PAE_COMB_DIFF_A);

    assign sel_curr[0] = comb_own ? ia : ia_minus_ib;
    assign sel_curr[1] = ib;
    assign sel_curr[2] = (input_combination_select == pae_pkg::PAE_COMB_DIFF_AC) ?
                         ic_minus_ib : ic;
    assign sel_volt[0] = (comb_own || comb_diff) ? voltage_a : '0;
    assign sel_volt[1] = comb_own ? voltage_b : '0;
    assign sel_volt[2] = (comb_own || comb_diff) ? voltage_c : '0;

    // per-phase power path and accumulator
    logic [2:0] rd_clear;
    pae_pkg::pae_power_t avg_power [3];
    pae_pkg::pae_acc_out_t acc_out [3];
    logic [2:0] half_full_evt;
    logic [2:0] sign_flip;

    generate
        for (gi = 0; gi < 3; gi++) begin : g_phase
            pae_pkg::pae_phase_cfg_t cfg;
            logic prev_sign;
            assign cfg.power_gain = power_gain[gi];
            assign cfg.divider = energy_divider;
            // only the active accumulator sees the creep enable
            assign cfg.creep_en = creep_threshold_enable;
            pae_power_path u_power (
                .clk_sys(clk_sys),
                .rst(rst),
                .tick(tick),
                .voltage(sel_volt[gi]),
                .current(sel_curr[gi]),
                .avg_power(avg_power[gi])
            );
            pae_phase_acc u_acc (
                .clk_sys(clk_sys),
                .rst(rst),
                .tick(tick),
                .avg_power(avg_power[gi]),
                .cfg(cfg),
                .clear(rd_clear[gi]),
                .acc_out(acc_out[gi])
            );
            assign half_full_evt[gi] = acc_out[gi].half_full_evt;
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    prev_sign <= 1'b0;
                end else begin
                    prev_sign <= avg_power[gi][`PAE_POWER_W-1];
                end
            end
            // phase_selection bit 0 is phase A, bit 2 of the mode register
            assign sign_flip[gi] = phase_selection[gi] && (prev_sign != avg_power[gi][`PAE_POWER_W-1]);
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            phase_sign_negative <= '0;
            total_active_power <= '0;
        end else begin
            phase_sign_negative <= phase_selection &
                {avg_power[2][`PAE_POWER_W-1], avg_power[1][`PAE_POWER_W-1],
                 avg_power[0][`PAE_POWER_W-1]};
            total_active_power <= (phase_selection[0] ? (`PAE_ADDEND_W+2)'(acc_out[0].addend) : '0)
                + (phase_selection[1] ? (`PAE_ADDEND_W+2)'(acc_out[1].addend) : '0)
                + (phase_selection[2] ? (`PAE_ADDEND_W+2)'(acc_out[2].addend) : '0);
        end
    end

    // Avalon-MM slave: one wait cycle, answer on the second cycle
    logic ack;
    logic bus_req;
    logic wr_take;
    logic rd_take;
    logic [31:0] wmask;
    logic [31:0] rd_mux;

    assign bus_req = avs_read || avs_write;
    assign avs_waitrequest = bus_req && !ack;
    assign wr_take = avs_write && ack;
    assign rd_take = avs_read && ack;
    assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    logic hit_div, hit_comp, hit_line, hit_clr, hit_mask;
    logic [2:0] hit_energy;
    logic [2:0] hit_pgain;
    logic [2:0] hit_current_gain;

    assign hit_energy[0] = (avs_address == `PAE_OFS_ENERGY_A);
    assign hit_energy[1] = (avs_address == `PAE_OFS_ENERGY_B);
    assign hit_energy[2] = (avs_address == `PAE_OFS_ENERGY_C);
    assign hit_div = (avs_address == `PAE_OFS_DIVIDER);
    assign hit_comp = (avs_address == `PAE_OFS_COMP_MODE);
    assign hit_line = (avs_address == `PAE_OFS_LINE_MODE);
    assign hit_clr = (avs_address == `PAE_OFS_INT_CLEAR);
    assign hit_mask = (avs_address == `PAE_OFS_INT_MASK);
    assign hit_pgain[0] = (avs_address == `PAE_OFS_PGAIN_A);
    assign hit_pgain[1] = (avs_address == `PAE_OFS_PGAIN_B);
    assign hit_pgain[2] = (avs_address == `PAE_OFS_PGAIN_C);
    assign hit_current_gain[0] = (avs_address == `PAE_OFS_CURRENT_GAIN_A);
    assign hit_current_gain[1] = (avs_address == `PAE_OFS_CURRENT_GAIN_B);
    assign hit_current_gain[2] = (avs_address == `PAE_OFS_CURRENT_GAIN_C);

    // clear acts at the answer edge, after the value was captured
    assign rd_clear = (rd_take && clear_on_read_enable) ? hit_energy : 3'h0;

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_energy[0]) begin
            rd_mux = {16'h0000, acc_out[0].energy};
        end else if (hit_energy[1]) begin
            rd_mux = {16'h0000, acc_out[1].energy};
        end else if (hit_energy[2]) begin
            rd_mux = {16'h0000, acc_out[2].energy};
        end else if (hit_div) begin
            rd_mux = {24'h00_0000, energy_divider};
        end else if (hit_comp) begin
            rd_mux = {24'h00_0000, compensation_mode_reg};
        end else if (hit_line) begin
            rd_mux = {24'h00_0000, line_cycle_mode_reg};
        end else if (avs_address == `PAE_OFS_INT_STATUS) begin
            rd_mux = {30'h0000_0000, int_status};
        end else if (hit_mask) begin
            rd_mux = {30'h0000_0000, energy_half_full_mask};
        end else if (hit_pgain[0] || hit_pgain[1] || hit_pgain[2]) begin
            rd_mux = {20'h0_0000, hit_pgain[0] ? power_gain[0] :
                      (hit_pgain[1] ? power_gain[1] : power_gain[2])};
        end else if (hit_current_gain[0] || hit_current_gain[1] || hit_current_gain[2]) begin
            rd_mux = {20'h0_0000, hit_current_gain[0] ? current_gain[0] :
                      (hit_current_gain[1] ? current_gain[1] : current_gain[2])};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ack <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            ack <= bus_req && !ack;
            if (avs_read && !ack) begin
                avs_readdata <= rd_mux;
            end
        end
    end

    logic [31:0] wd;
    assign wd = avs_writedata & wmask;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            energy_divider <= `PAE_DIV_RST;
            compensation_mode_reg <= `PAE_COMP_RST;
            line_cycle_mode_reg <= `PAE_LINE_RST;
            energy_half_full_mask <= `PAE_MASK_RST;
            power_gain <= {3{`PAE_GAIN_RST}};
            current_gain <= {3{`PAE_GAIN_RST}};
        end else if (wr_take && avs_byteenable[0]) begin
            if (hit_div) begin
                energy_divider <= wd[7:0];
            end
            if (hit_comp) begin
                compensation_mode_reg <= wd[7:0];
            end
            if (hit_line) begin
                line_cycle_mode_reg <= wd[7:0];
            end
            if (hit_mask) begin
                energy_half_full_mask <= wd[`PAE_INT_W-1:0];
            end
            for (int k = 0; k < 3; k++) begin
                if (hit_pgain[k] && avs_byteenable[1]) begin
                    power_gain[k] <= wd[`PAE_GAIN_W-1:0];
                end
                if (hit_current_gain[k] && avs_byteenable[1]) begin
                    current_gain[k] <= wd[`PAE_GAIN_W-1:0];
                end
            end
        end
    end

    // sticky status: a new event in the clearing cycle survives the clear
    logic [`PAE_INT_W-1:0] int_set;
    logic [`PAE_INT_W-1:0] int_clr;

    assign int_set[`PAE_INT_HALF_BIT] = |half_full_evt;
    // sign_flip lasts the one cycle after the tick edge, so it is not gated by tick
    assign int_set[`PAE_INT_SIGN_BIT] = |sign_flip;
    assign int_clr = (wr_take && hit_clr && avs_byteenable[0]) ? avs_writedata[`PAE_INT_W-1:0] : '0;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            int_status <= '0;
            irq_n <= 1'b1;
        end else begin
            int_status <= (int_status & ~int_clr) | int_set;
            irq_n <= !(|(int_status & energy_half_full_mask));
        end
    end
endmodule

`default_nettype wire

// ### tb/pae_top_sva.sv
// checker of the register port and interrupt of the energy accumulator top
// assumes a bind to pae_top and sight of its ports only
`timescale 1ns/1ps
`default_nettype none
`include "pae_defines.svh"
module pae_top_sva (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [`PAE_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic irq_n
);
    logic [1:0] mask_q;
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    sequence held_s;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence rd_s;
        avs_read && !avs_waitrequest;
    endsequence
    // shadow of the mask, taken at the accepting edge like the slave does
    always_ff @(posedge clk_sys) begin
        if (rst)
            mask_q <= 2'h0;
        else if (avs_write && !avs_waitrequest && avs_address == 8'h20 && avs_byteenable[0])
            mask_q <= avs_writedata[1:0];
    end
    first_wait_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("request not held off in its first cycle");
    one_wait_a: assert property (held_s |=> !avs_waitrequest)
        else $error("request waited more than one cycle");
    idle_ready_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("waitrequest high while idle");
    unmapped_zero_a: assert property (rd_s ##0 (avs_address > 8'h38) |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    energy_width_a: assert property (rd_s ##0 (avs_address <= 8'h08) |->
        avs_readdata[31:16] == 16'h0) else $error("energy read wider than 16 bits");
    divider_width_a: assert property (rd_s ##0 (avs_address == 8'h0C) |->
        avs_readdata[31:8] == 24'h0) else $error("divider read wider than 8 bits");
    clear_reads_a: assert property (rd_s ##0 (avs_address == 8'h1C) |->
        avs_readdata == 32'h0) else $error("clear register not read as zero");
    irq_masked_a: assert property (!irq_n |-> $past(mask_q) != 2'h0)
        else $error("interrupt low with every source masked");
    reset_irq_a: assert property ($fell(rst) |-> irq_n)
        else $error("interrupt low right after reset");
endmodule
bind pae_top pae_top_sva i_sva (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq_n(irq_n));
`default_nettype wire

// ### tb/tb.sv
// self-checking bench of the phase active energy accumulator top
// assumes the top alone, its register port driven by the bus task below
`timescale 1ns/1ps
`default_nettype none
`include "pae_defines.svh"
module tb;
    logic clk_sys, rst, avs_read, avs_write, avs_waitrequest, irq_n;
    logic [7:0] avs_address;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata, avs_writedata, rd;
    logic [2:0] neg;
    logic signed [`PAE_ADDEND_W+1:0] tot;
    pae_pkg::pae_sample_t v, c, cb, ga;
    int mismatches, comparisons, cyc;
    logic [7:0] ofs [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
    logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h1C, 8'h00, 8'h00, 8'h00};
    logic [31:0] cx [4] = '{32'h140, 32'h80, 32'hC0, 32'h0};
    pae_top i_dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .voltage_a(v), .voltage_b(v), .voltage_c(v),
        .current_a(c), .current_b(cb), .current_c(c), .gained_current_a(ga),
        .gained_current_b(), .gained_current_c(), .phase_sign_negative(neg),
        .total_active_power(tot), .irq_n(irq_n));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 60000) begin
            mismatches++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // request held until waitrequest is sampled low at a rising edge; data taken there
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        avs_byteenable = 4'hF;
        {v, c, cb} = '0;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (ofs[i]) begin
            bus(1'b0, ofs[i], 32'h0);
            chk(rd, {24'h0, rv[i]});
        end
        bus(1'b1, 8'h0C, 32'hFF);
        bus(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'hFF);
        bus(1'b1, 8'h0C, 32'h0);
        bus(1'b1, 8'h40, 32'h55);
        bus(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        c <= 24'h100000;
        // current gain is only touched outside combination mode zero
        bus(1'b1, 8'h10, 32'h1D);
        bus(1'b1, 8'h30, 32'h7FF);
        wt(3);
        chk(ga, 32'h17FF00);
        bus(1'b1, 8'h30, 32'h0);
        bus(1'b1, 8'h10, 32'h1C);
        {v, c, cb} <= {3{24'h001000}};
        wt(4400);
        chk(tot, 32'h6);
        bus(1'b1, 8'h10, 32'h9C);
        wt(4400);
        chk(tot, 32'h0);
        bus(1'b1, 8'h10, 32'h1C);
        {v, c, cb} <= {24'h100000, 24'h000400, 24'h000200};
        wt(4400);
        chk(tot, cx[0]);
        bus(1'b1, 8'h0C, 32'h1);
        wt(100);
        chk(tot, cx[0]);
        bus(1'b1, 8'h0C, 32'h3);
        wt(100);
        chk(tot, 32'h69);
        bus(1'b1, 8'h0C, 32'h0);
        bus(1'b1, 8'h24, 32'h800);
        wt(100);
        chk(tot, 32'h100);
        bus(1'b1, 8'h24, 32'h0);
        for (int k = 1; k < 4; k++) begin
            bus(1'b1, 8'h10, 32'h1C | k);
            wt(4400);
            chk(tot, cx[k]);
        end
        bus(1'b1, 8'h10, 32'h1C);
        bus(1'b1, 8'h20, 32'h2);
        bus(1'b1, 8'h14, 32'h40);
        {v, c, cb} <= {3{24'h7FFFFF}};
        bus(1'b0, 8'h00, 32'h0);
        wt(4000);
        bus(1'b0, 8'h00, 32'h0);
        chk(rd[31:15] == 17'h0 && rd != 32'h0, 32'h1);
        bus(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0);
        {c, cb} <= {2{24'h800001}};
        wt(4000);
        bus(1'b0, 8'h00, 32'h0);
        chk(rd[31:15], 32'h1);
        wt(2);
        chk(neg, 32'h7);
        chk(irq_n, 32'h0);
        bus(1'b1, 8'h14, 32'h0);
        // let the emptied register cross zero again before reading the status
        wt(100);
        bus(1'b0, 8'h18, 32'h0);
        chk(rd[1:0], 32'h3);
        bus(1'b1, 8'h20, 32'h1);
        bus(1'b1, 8'h1C, 32'h2);
        wt(3);
        chk(irq_n, 32'h0);
        bus(1'b1, 8'h20, 32'h0);
        wt(3);
        chk(irq_n, 32'h1);
        bus(1'b1, 8'h1C, 32'h3);
        bus(1'b0, 8'h18, 32'h0);
        chk(rd, 32'h0);
        summarize();
    end
endmodule
`default_nettype wire
